// ===== hdl/fsr_pkg.sv
package fsr_pkg;

    localparam int NUM_CH      = 8;
    localparam int HIST_DEPTH  = 12;
    localparam int VAL_W       = 32;
    localparam int MAG_W       = 6;
    localparam int NUM_MAG     = 64;
    localparam int NUM_STG     = 7;
    localparam int NUM_RST_SRC = 4;
    localparam int ADDR_W      = 6;
    localparam int REC_IDX_W   = 4;
    localparam int CH_IDX_W    = 3;

    // Selector codes below CUR_END are current-derived, below VOLT_END
    // voltage-derived, the rest need both kinds of input
    localparam logic [MAG_W-1:0] MAG_CUR_END  = 6'h10;
    localparam logic [MAG_W-1:0] MAG_VOLT_END = 6'h20;
    localparam logic [MAG_W-1:0] MAG_COMPUTED_RESIDUAL_CURRENT_MAGNITUDE
        = 6'h0f;
    localparam logic [MAG_W-1:0] MAG_COMPUTED_RESIDUAL_VOLTAGE_MAGNITUDE
        = 6'h1f;

    // Trip input bit order
    localparam int STG_OVERCURRENT = 0;
    localparam int STG_UNBALANCE   = 1;
    localparam int STG_EARTH_FAULT = 2;
    localparam int STG_FREQUENCY   = 3;
    localparam int STG_VOLTAGE     = 4;
    localparam int STG_POWER       = 5;
    localparam int STG_THERMAL     = 6;
    localparam logic [2:0] TRIG_USER = 3'h7;
    localparam logic [2:0] STAGE_NONE = 3'h0;

    // Byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL       = 6'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS     = 6'h04;
    localparam logic [ADDR_W-1:0] ADDR_CHSEL_BASE = 6'h08;
    localparam logic [ADDR_W-1:0] ADDR_CHSEL_LAST = 6'h24;
    localparam logic [ADDR_W-1:0] ADDR_HIST_SEL   = 6'h28;
    localparam logic [ADDR_W-1:0] ADDR_HIST_DATA  = 6'h2c;
    localparam logic [ADDR_W-1:0] ADDR_HIST_INFO  = 6'h30;

    typedef struct packed {
        logic [1:0] rst_sel;
        logic [2:0] trig_sel;
        logic       evt_off_en;
        logic       evt_on_en;
        logic       fault_display_enable;
        logic       volt_type_en;
        logic       oc_type_en;
        logic       primary;
    } fsr_ctrl_t;
    localparam fsr_ctrl_t CTRL_RST = 11'h000;

    typedef struct packed {
        logic [7:0]           cap_cnt;
        logic                 held;
        logic                 trig;
        logic [REC_IDX_W-1:0] count;
    } fsr_status_t;

    typedef struct packed {
        logic                 primary;
        logic [2:0]           stage;
        logic [2:0]           oc_type;
        logic [4:0]           volt_type;
    } fsr_info_t;

    typedef struct packed {
        fsr_info_t                        info;
        logic [NUM_CH-1:0][VAL_W-1:0]     val;
    } fsr_rec_t;

    typedef struct packed {
        logic     valid;
        fsr_rec_t rec;
    } fsr_disp_t;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [31:0]       writedata;
        logic [3:0]        byteenable;
    } fsr_av_req_t;

endpackage

// ===== hdl/fsr_chan_sel.sv
`timescale 1ns/1ps
`default_nettype none
module fsr_chan_sel #(
    parameter bit CUR_FITTED  = 1'b1,
    parameter bit VOLT_FITTED = 1'b1
) (
    // Clock and reset
    input  wire logic                                    sys_clk_i,
    input  wire logic                                    rst_n_i,
    // Selector write
    input  wire logic                                    wr_i,
    input  wire logic [fsr_pkg::MAG_W-1:0]               sel_i,
    // Measurements
    input  wire logic                                    primary_i,
    input  wire logic [fsr_pkg::NUM_MAG-1:0][fsr_pkg::VAL_W-1:0] pu_i,
    input  wire logic [fsr_pkg::NUM_MAG-1:0][fsr_pkg::VAL_W-1:0] pri_i,
    // Results
    output logic      [fsr_pkg::MAG_W-1:0]               sel_o,
    output logic      [fsr_pkg::VAL_W-1:0]               value_o
);
    import fsr_pkg::*;

    localparam logic [MAG_W-1:0] SEL_RST = CUR_FITTED ?
        MAG_COMPUTED_RESIDUAL_CURRENT_MAGNITUDE :
        MAG_COMPUTED_RESIDUAL_VOLTAGE_MAGNITUDE;

    typedef struct packed {
        logic [MAG_W-1:0] sel;
    } fsr_cs_state_t;

    fsr_cs_state_t st;
    fsr_cs_state_t next_st;
    logic          allowed;

    always_comb begin
        // A code needing an input that is not fitted is refused
        if (sel_i < MAG_CUR_END) begin
            allowed = CUR_FITTED;
        end else if (sel_i < MAG_VOLT_END) begin
            allowed = VOLT_FITTED;
        end else begin
            allowed = CUR_FITTED && VOLT_FITTED;
        end
        next_st = st;
        if (wr_i && allowed) begin
            next_st.sel = sel_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st.sel <= SEL_RST;
        end else begin
            st <= next_st;
        end
    end

    assign sel_o   = st.sel;
    assign value_o = primary_i ? pri_i[st.sel] : pu_i[st.sel];

    property p_sel_refused;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_i && !allowed) |=> (st.sel == $past(st.sel));
    endproperty
    a_sel_refused: assert property (p_sel_refused)
        else $error("refused selector code was stored");

endmodule
`default_nettype wire

// ===== hdl/fsr_history.sv
`timescale 1ns/1ps
`default_nettype none
module fsr_history #(
    parameter int DEPTH = fsr_pkg::HIST_DEPTH
) (
    // Clock and reset
    input  wire logic                             sys_clk_i,
    input  wire logic                             rst_n_i,
    // Write side
    input  wire logic                             we_i,
    input  wire fsr_pkg::fsr_rec_t                rec_i,
    // Read side, index 0 is the newest recording
    input  wire logic [fsr_pkg::REC_IDX_W-1:0]    rd_idx_i,
    output fsr_pkg::fsr_rec_t                     rd_rec_o,
    output logic      [fsr_pkg::REC_IDX_W-1:0]    count_o
);
    import fsr_pkg::*;

    localparam logic [REC_IDX_W-1:0] LAST  = REC_IDX_W'(DEPTH - 1);
    localparam logic [REC_IDX_W-1:0] FULL  = REC_IDX_W'(DEPTH);
    localparam logic [REC_IDX_W-1:0] ONE   = 4'h1;

    typedef struct packed {
        logic [REC_IDX_W-1:0] wr_ptr;
        logic [REC_IDX_W-1:0] count;
    } fsr_hist_state_t;

    fsr_hist_state_t      st;
    fsr_hist_state_t      next_st;
    fsr_rec_t             mem [DEPTH];
    logic [REC_IDX_W:0]   back;
    logic [REC_IDX_W-1:0] rd_ptr;

    always_comb begin
        next_st = st;
        if (we_i) begin
            next_st.wr_ptr = (st.wr_ptr == LAST) ? '0 : st.wr_ptr + ONE;
            // Once full the oldest slot is overwritten
            if (st.count != FULL) begin
                next_st.count = st.count + ONE;
            end
        end
        back = {1'b0, st.wr_ptr} + {1'b0, FULL} - {1'b0, rd_idx_i}
               - {1'b0, ONE};
        rd_ptr = (back >= {1'b0, FULL}) ?
            REC_IDX_W'(back - {1'b0, FULL}) : back[REC_IDX_W-1:0];
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Data array carries no reset; count guards stale slots
    always_ff @(posedge sys_clk_i) begin
        if (we_i) begin
            mem[st.wr_ptr] <= rec_i;
        end
    end

    assign rd_rec_o = (rd_idx_i < st.count) ? mem[rd_ptr] : '0;
    assign count_o  = st.count;

    property p_hist_bound;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (we_i && st.count == FULL) |=> (st.count == FULL);
    endproperty
    a_hist_bound: assert property (p_hist_bound)
        else $error("history count left full state");

endmodule
`default_nettype wire

// ===== hdl/fsr_top.sv
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fsr_top #(
    parameter bit CUR_FITTED  = 1'b1,
    parameter bit VOLT_FITTED = 1'b1
) (
    // Clock and reset
    input  wire logic                                    sys_clk_i,
    input  wire logic                                    rst_n_i,
    // Register bus, Avalon-MM slave
    input  wire fsr_pkg::fsr_av_req_t                    av_req_i,
    output logic      [31:0]                             av_readdata_o,
    output logic                                         av_waitrequest_o,
    // Protection stages and measurement logic
    input  wire logic [fsr_pkg::NUM_STG-1:0]             trips_i,
    input  wire logic                                    user_trig_i,
    input  wire logic [2:0]                              oc_type_i,
    input  wire logic [4:0]                              volt_type_i,
    input  wire logic [fsr_pkg::NUM_MAG-1:0][fsr_pkg::VAL_W-1:0] meas_pu_i,
    input  wire logic [fsr_pkg::NUM_MAG-1:0][fsr_pkg::VAL_W-1:0] meas_pri_i,
    input  wire logic [fsr_pkg::NUM_RST_SRC-1:0]         disp_reset_i,
    input  wire logic [31:0]                             timestamp_i,
    // Display and supervisory outputs
    output fsr_pkg::fsr_disp_t                           disp_o,
    output fsr_pkg::fsr_info_t                           scada_o,
    // Events
    output logic                                         evt_on_o,
    output logic                                         evt_off_o,
    output logic      [31:0]                             evt_time_o
);
    import fsr_pkg::*;

    localparam logic [7:0] CNT_ONE = 8'h01;

    typedef struct packed {
        fsr_ctrl_t                ctrl;
        logic                     waitreq;
        logic [31:0]              rdata;
        logic [CH_IDX_W-1:0]      hist_ch;
        logic [REC_IDX_W-1:0]     hist_rec;
        logic                     trig_q;
        logic [NUM_STG-1:0]       trips_q;
        logic                     held;
        fsr_rec_t                 hold;
        fsr_disp_t                disp;
        fsr_info_t                scada;
        logic                     evt_on;
        logic                     evt_off;
        logic [31:0]              evt_time;
        logic [7:0]               cap_cnt;
    } fsr_top_state_t;

    fsr_top_state_t                st;
    fsr_top_state_t                next_st;

    logic [NUM_CH-1:0][MAG_W-1:0]  ch_sel;
    logic [NUM_CH-1:0][VAL_W-1:0]  ch_val;
    logic [NUM_CH-1:0]             chsel_wr;
    logic [REC_IDX_W-1:0]          hist_count;
    fsr_rec_t                      hist_rd;
    fsr_rec_t                      new_rec;
    fsr_status_t                   status;
    logic                          acc;
    logic                          wr;
    logic [31:0]                   cur_word;
    logic [31:0]                   wmerge;
    logic                          trig_now;
    logic                          cap;
    logic                          trip_rise;
    logic                          disp_clr;
    logic [2:0]                    stage_id;
    logic [ADDR_W-1:0]             ch_off;
    logic [CH_IDX_W-1:0]           ch_addr;
    logic                          ch_hit;

    // One wait cycle on every access keeps the read path fully registered
    assign acc = (av_req_i.read || av_req_i.write) && st.waitreq;
    assign wr  = acc && av_req_i.write;

    assign ch_off  = av_req_i.address - ADDR_CHSEL_BASE;
    assign ch_addr = ch_off[CH_IDX_W+1:2];
    assign ch_hit  = (av_req_i.address >= ADDR_CHSEL_BASE)
                  && (av_req_i.address <= ADDR_CHSEL_LAST)
                  && (av_req_i.address[1:0] == 2'h0);

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            assign chsel_wr[g] = wr && ch_hit
                && (ch_addr == CH_IDX_W'(g));
            fsr_chan_sel #(
                .CUR_FITTED  (CUR_FITTED),
                .VOLT_FITTED (VOLT_FITTED)
            ) u_chan (
                .sys_clk_i (sys_clk_i),
                .rst_n_i   (rst_n_i),
                .wr_i      (chsel_wr[g]),
                .sel_i     (wmerge[MAG_W-1:0]),
                .primary_i (st.ctrl.primary),
                .pu_i      (meas_pu_i),
                .pri_i     (meas_pri_i),
                .sel_o     (ch_sel[g]),
                .value_o   (ch_val[g])
            );
        end
    endgenerate

    fsr_history u_hist (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .we_i      (cap),
        .rec_i     (new_rec),
        .rd_idx_i  (st.hist_rec),
        .rd_rec_o  (hist_rd),
        .count_o   (hist_count)
    );

    // Trigger and recording content
    always_comb begin
        if (st.ctrl.trig_sel == TRIG_USER) begin
            trig_now = user_trig_i;
        end else begin
            trig_now = trips_i[st.ctrl.trig_sel];
        end
        cap       = trig_now && !st.trig_q;
        trip_rise = |(trips_i & ~st.trips_q);
        disp_clr  = disp_reset_i[st.ctrl.rst_sel];
        stage_id  = STAGE_NONE;
        for (int i = NUM_STG - 1; i >= 0; i--) begin
            if (trips_i[i]) begin
                stage_id = 3'(i + 1);
            end
        end
        new_rec.info.primary   = st.ctrl.primary;
        new_rec.info.stage     = stage_id;
        new_rec.info.oc_type   = st.ctrl.oc_type_en ? oc_type_i : '0;
        new_rec.info.volt_type = st.ctrl.volt_type_en ? volt_type_i : '0;
        new_rec.val            = ch_val;
    end

    // Register readback and byte-lane merge
    always_comb begin
        status.cap_cnt = st.cap_cnt;
        status.held    = st.held;
        status.trig    = st.trig_q;
        status.count   = hist_count;
        cur_word       = '0;
        if (ch_hit) begin
            cur_word = 32'(ch_sel[ch_addr]);
        end else begin
            case (av_req_i.address)
                ADDR_CTRL:      cur_word = 32'(st.ctrl);
                ADDR_STATUS:    cur_word = 32'(status);
                ADDR_HIST_SEL:  cur_word = 32'({st.hist_ch, st.hist_rec});
                ADDR_HIST_DATA: cur_word = hist_rd.val[st.hist_ch];
                ADDR_HIST_INFO: cur_word = 32'(hist_rd.info);
                default:        cur_word = '0;
            endcase
        end
        for (int b = 0; b < 4; b++) begin
            wmerge[b*8 +: 8] = av_req_i.byteenable[b] ?
                av_req_i.writedata[b*8 +: 8] : cur_word[b*8 +: 8];
        end
    end

    always_comb begin
        next_st = st;
        // Bus slave
        next_st.waitreq = !acc;
        if (acc && av_req_i.read) begin
            next_st.rdata = cur_word;
        end
        if (wr) begin
            case (av_req_i.address)
                ADDR_CTRL: begin
                    next_st.ctrl = fsr_ctrl_t'(wmerge[$bits(fsr_ctrl_t)-1:0]);
                end
                ADDR_HIST_SEL: begin
                    {next_st.hist_ch, next_st.hist_rec} =
                        wmerge[CH_IDX_W+REC_IDX_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // Capture
        next_st.trig_q  = trig_now;
        next_st.trips_q = trips_i;
        if (cap) begin
            next_st.cap_cnt = st.cap_cnt + CNT_ONE;
            next_st.scada   = new_rec.info;
        end
        // Live display, a trip wins over a same-cycle clear
        if (trip_rise) begin
            next_st.held = 1'b1;
            next_st.hold = new_rec;
        end else if (disp_clr) begin
            next_st.held = 1'b0;
            next_st.hold = '0;
        end
        next_st.disp.valid = next_st.held
            && next_st.ctrl.fault_display_enable;
        next_st.disp.rec = next_st.disp.valid ? next_st.hold : '0;
        // Events
        next_st.evt_on  = cap && st.ctrl.evt_on_en;
        next_st.evt_off = !trig_now && st.trig_q
                          && st.ctrl.evt_off_en;
        if (cap || (!trig_now && st.trig_q)) begin
            next_st.evt_time = timestamp_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st         <= '0;
            st.ctrl    <= CTRL_RST;
            st.waitreq <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign av_readdata_o    = st.rdata;
    assign av_waitrequest_o = st.waitreq;
    assign disp_o           = st.disp;
    assign scada_o          = st.scada;
    assign evt_on_o         = st.evt_on;
    assign evt_off_o        = st.evt_off;
    assign evt_time_o       = st.evt_time;

    property p_cap_count;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cap |=> (st.cap_cnt == $past(st.cap_cnt) + CNT_ONE);
    endproperty
    a_cap_count: assert property (p_cap_count)
        else $error("capture did not add a recording");

    property p_cap_edge;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (trig_now && !st.trig_q) |-> ##1 (st.trig_q && hist_count != '0);
    endproperty
    a_cap_edge: assert property (p_cap_edge)
        else $error("trigger edge not captured at once");

    property p_scale;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cap |=> (st.scada.primary == $past(st.ctrl.primary));
    endproperty
    a_scale: assert property (p_scale)
        else $error("recording scale differs from setting");

    property p_oc_type_gate;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (cap && !st.ctrl.oc_type_en) |=> (st.scada.oc_type == 3'h0);
    endproperty
    a_oc_type_gate: assert property (p_oc_type_gate)
        else $error("overcurrent type stored while disabled");

    property p_trip_display;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        trip_rise |=> st.held ##0 (st.disp.valid
            == st.ctrl.fault_display_enable);
    endproperty
    a_trip_display: assert property (p_trip_display)
        else $error("trip did not load the fault display");

    property p_disp_suppress;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !st.ctrl.fault_display_enable |-> (!disp_o.valid && disp_o.rec == '0);
    endproperty
    a_disp_suppress: assert property (p_disp_suppress)
        else $error("display shown while disabled");

    property p_disp_clear;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (disp_clr && !trip_rise) |=> (!st.held && !disp_o.valid);
    endproperty
    a_disp_clear: assert property (p_disp_clear)
        else $error("display reset input ignored");

    property p_scada;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cap |=> (scada_o.stage == $past(stage_id));
    endproperty
    a_scada: assert property (p_scada)
        else $error("supervisory stage not updated");

    property p_evt_on;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (cap && st.ctrl.evt_on_en) |=> evt_on_o ##1 !evt_on_o;
    endproperty
    a_evt_on: assert property (p_evt_on)
        else $error("trigger on event missing or too long");

    property p_evt_mask;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !st.ctrl.evt_off_en |=> !evt_off_o;
    endproperty
    a_evt_mask: assert property (p_evt_mask)
        else $error("masked trigger off event raised");

    property p_evt_off;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (!trig_now && st.trig_q && st.ctrl.evt_off_en) |=> evt_off_o;
    endproperty
    a_evt_off: assert property (p_evt_off)
        else $error("trigger off event missing");

    property p_evt_time;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cap |=> (evt_time_o == $past(timestamp_i));
    endproperty
    a_evt_time: assert property (p_evt_time)
        else $error("event time stamp not taken at trigger");

    property p_volt_type_gate;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (cap && !st.ctrl.volt_type_en) |=> (st.scada.volt_type == 5'h00);
    endproperty
    a_volt_type_gate: assert property (p_volt_type_gate)
        else $error("voltage type stored while disabled");

    property p_hold_values;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        trip_rise |=> (st.hold.val == $past(ch_val));
    endproperty
    a_hold_values: assert property (p_hold_values)
        else $error("fault display values not latched on trip");

    property p_no_retrigger;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (trig_now && st.trig_q) |=> (st.cap_cnt == $past(st.cap_cnt));
    endproperty
    a_no_retrigger: assert property (p_no_retrigger)
        else $error("held trigger made another recording");

endmodule
`default_nettype wire

// ===== tb/fsr_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module fsr_far_end (
    // Commands from the bench
    input  wire logic [fsr_pkg::NUM_STG-1:0]  trip_cmd_i,
    // Protection stages and measurement logic
    output logic      [fsr_pkg::NUM_STG-1:0]  trips_o,
    output logic [fsr_pkg::NUM_MAG-1:0][fsr_pkg::VAL_W-1:0] pu_o,
    output logic [fsr_pkg::NUM_MAG-1:0][fsr_pkg::VAL_W-1:0] pri_o
);
    import fsr_pkg::*;
    // Per-unit and primary differ in every bit of the top nibble, so a scaling mix-up shows
    always_comb begin
        trips_o = trip_cmd_i;
        for (int i = 0; i < NUM_MAG; i++) begin
            pu_o[i]  = 32'ha000_0000 | 32'(i);
            pri_o[i] = 32'h5000_0000 | 32'(i);
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fsr_pkg::*;
    logic        sys_clk_i, rst_n_i, user_trig, evt_on, evt_off, wreq;
    fsr_av_req_t req;
    logic [31:0] rdata, ts, evt_time, q, t0;
    logic [6:0]  trip_cmd, trips;
    logic [2:0]  oc_type;
    logic [4:0]  volt_type;
    logic [3:0]  disp_rst;
    logic [NUM_MAG-1:0][VAL_W-1:0] pu, pri;
    fsr_disp_t   disp;
    fsr_info_t   scada;
    int          error_cnt, samples_checked;

    fsr_far_end fsr_far_end_inst (.trip_cmd_i(trip_cmd), .trips_o(trips),
        .pu_o(pu), .pri_o(pri));
    fsr_top #(.CUR_FITTED(1'b1), .VOLT_FITTED(1'b0)) fsr_top_inst (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .av_req_i(req),
        .av_readdata_o(rdata), .av_waitrequest_o(wreq), .trips_i(trips),
        .user_trig_i(user_trig), .oc_type_i(oc_type),
        .volt_type_i(volt_type), .meas_pu_i(pu), .meas_pri_i(pri),
        .disp_reset_i(disp_rst), .timestamp_i(ts), .disp_o(disp),
        .scada_o(scada), .evt_on_o(evt_on), .evt_off_o(evt_off),
        .evt_time_o(evt_time));

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) ts <= ts + 32'h1;

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask

    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        req <= '{a, !wr, wr, d, 4'hf};
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        r = rdata;
        req.read  <= 1'b0;
        req.write <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            complete_run();
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string nm, input logic [5:0] a,
                          input logic [31:0] e);
        bus(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask

    // Trip command changes to t in cycle c0; returns one cycle after its edge
    task automatic trip_edge(input logic [6:0] t);
        @(posedge sys_clk_i);
        trip_cmd <= t;
        #1 t0 = ts;
        @(posedge sys_clk_i);
        #1;
    endtask

    task automatic t_regs();
        rd_chk("ctrl", ADDR_CTRL, 32'h0);
        rd_chk("sel0", ADDR_CHSEL_BASE, 32'h0f);
        wr(6'h0c, 32'h03);
        rd_chk("sel1", 6'h0c, 32'h03);
        wr(6'h10, 32'h15);
        rd_chk("sel2", 6'h10, 32'h0f);
        wr(6'h3c, 32'hffff_ffff);
        rd_chk("unmapped", 6'h3c, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_capture();
        wr(ADDR_CTRL, 32'h03e);
        oc_type   <= 3'h5;
        volt_type <= 5'h09;
        trip_edge(7'h05);
        chk("stage", 32'h1, 32'(scada.stage));
        chk("oc", 32'h5, 32'(scada.oc_type));
        chk("volt", 32'h9, 32'(scada.volt_type));
        chk("evt_on", 32'h1, 32'(evt_on));
        chk("evt_time", t0, evt_time);
        chk("disp_valid", 32'h1, 32'(disp.valid));
        chk("disp_val", 32'ha000_0003, disp.rec.val[1]);
        trip_edge(7'h00);
        chk("evt_off", 32'h1, 32'(evt_off));
        wr(ADDR_HIST_SEL, 32'h10);
        rd_chk("hist_val", ADDR_HIST_DATA, 32'ha000_0003);
        wr(ADDR_CTRL, 32'h036);
        #1 chk("disp_off", 32'h0, 32'(disp.valid));
        wr(ADDR_CTRL, 32'h03f);
        trip_edge(7'h10);
        chk("scada_kept", 32'h1, 32'(scada.stage));
        chk("disp_stage", 32'h5, 32'(disp.rec.info.stage));
        chk("disp_pri", 32'h5000_0003, disp.rec.val[1]);
        @(posedge sys_clk_i);
        trip_cmd <= 7'h00;
        disp_rst <= 4'h1;
        @(posedge sys_clk_i);
        disp_rst <= 4'h0;
        @(posedge sys_clk_i);
        #1 chk("disp_clr", 32'h0, 32'(disp.valid));
        chk("disp_rec", 32'h0, disp.rec.val[1]);
        $display("test capture done");
    endtask

    task automatic t_wrap();
        wr(ADDR_CTRL, 32'h1fc);
        for (int k = 0; k < 13; k++) begin
            @(posedge sys_clk_i);
            volt_type <= 5'(k);
            user_trig <= 1'b1;
            @(posedge sys_clk_i);
            user_trig <= 1'b0;
        end
        @(posedge sys_clk_i);
        #1 chk("volt_new", 32'hc, 32'(scada.volt_type));
        chk("oc_off", 32'h0, 32'(scada.oc_type));
        bus(1'b0, ADDR_STATUS, 32'h0, q);
        chk("count", 32'hc, 32'(q[3:0]));
        wr(ADDR_HIST_SEL, 32'h0b);
        rd_chk("oldest", ADDR_HIST_INFO, 32'h1);
        wr(ADDR_HIST_SEL, 32'h0c);
        rd_chk("beyond", ADDR_HIST_INFO, 32'h0);
        $display("test wrap done");
    endtask

    task automatic t_mask();
        wr(ADDR_CTRL, 32'h288);
        trip_edge(7'h04);
        chk("evt_on_mask", 32'h0, 32'(evt_on));
        chk("stage_ef", 32'h3, 32'(scada.stage));
        chk("disp_ef", 32'h1, 32'(disp.valid));
        @(posedge sys_clk_i);
        disp_rst <= 4'h1;
        @(posedge sys_clk_i);
        disp_rst <= 4'h2;
        #1 chk("disp_other_src", 32'h1, 32'(disp.valid));
        @(posedge sys_clk_i);
        disp_rst <= 4'h0;
        #1 chk("disp_sel_src", 32'h0, 32'(disp.valid));
        trip_edge(7'h00);
        chk("evt_off_mask", 32'h0, 32'(evt_off));
        $display("test mask done");
    endtask

    initial begin
        error_cnt = 0;
        samples_checked = 0;
        rst_n_i = 1'b0;
        req = '0;
        ts = 32'h0;
        trip_cmd = 7'h00;
        user_trig = 1'b0;
        oc_type = 3'h0;
        volt_type = 5'h00;
        disp_rst = 4'h0;
        repeat (12) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_capture();
        t_wrap();
        t_mask();
        complete_run();
    end
endmodule
`default_nettype wire
